// *** rtl/scan_transceiver.sv ***
// Boundary-scan 18-bit bus transceiver with test port and APB status
//
// Function
// - Enabled section drives per direction level
// - Disabled section floats both ports
// - Two independent nine-bit sections
// - Test mode: boundary cells own pins
// - Normal mode: scan never disturbs data
// - Sample on rising, change on falling
// - Shift TDI through register onto TDO
// - Controller steps only by sampled TMS; here the software hold also forces tmsEff high
// - Eight-bit serial instruction register
// - Boundary, control, bypass, identification registers
// - Signature compression and pseudo-random patterns
// - Standard plus extra instructions, even parity
// - Reset loads identification opcode, control 010
// - Five high TMS reach reset state
// - Reset clears boundary enable bits 43-40
// - Capture-IR loads fixed pattern 10000001
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
module scan_transceiver #(
  parameter logic [31:0] ID_VALUE = 32'h0A5C_3001  // Identification word, value arbitrary
) (
  input wire logic core_clk,               // System clock, 250 MHz
  input wire logic rst_n,                  // Synchronous reset, active low
  input wire logic [11:0] paddr,           // APB address
  input wire logic psel,                   // APB select
  input wire logic penable,                // APB enable
  input wire logic pwrite,                 // APB write
  input wire logic [31:0] pwdata,          // APB write data
  output logic [31:0] prdata,              // APB read data
  output logic pready,                     // APB ready
  output logic pslverr,                    // APB error on unmapped address
  input wire logic tck,                    // Test clock
  input wire logic tms,                    // Test mode select
  input wire logic tdi,                    // Test data in
  output logic tdo,                        // Test data out
  output logic tdoOe,                      // Test data out enable
  input wire logic [1:0] oeN,              // Section output enables, active low
  input wire logic [1:0] dir,              // Section directions
  input wire logic [17:0] aIn,             // A port pin levels
  output logic [17:0] aOut,                // A port drive value
  output logic [17:0] aOe,                 // A port drive enable
  input wire logic [17:0] bIn,             // B port pin levels
  output logic [17:0] bOut,                // B port drive value
  output logic [17:0] bOe                  // B port drive enable
);

  localparam int SW = bscan_pkg::SECT_W;
  localparam int AL = bscan_pkg::BSR_A_LO;
  localparam int BL = bscan_pkg::BSR_B_LO;
  localparam int OL = bscan_pkg::BSR_OE_LO;

  logic rstMeta, rstTckN;
  logic holdMeta, holdSync, tmsEff;
  bscan_pkg::pinBus_s pinMeta, pinSync;
  logic [3:0] ctlMeta, ctlSync;
  bscan_pkg::tapState_e tapState;
  bscan_pkg::tapCtl_s tap;
  logic [7:0] irShift, instr;
  logic [43:0] bsrShift, bsrUpd;
  logic [2:0] bcrShift, bcrUpd;
  logic [31:0] idShift;
  logic bypassReg;
  logic selBsr, selBcr, selId, testMode, hiz, drOut;
  logic ctrlHold;
  logic testMeta, testSync, tlrMeta, tlrSync;

  ////////////////////////////////////////////////////////////////////////////////
  // Test clock domain: reset, hold request and pin synchronisers
  always_ff @(posedge tck) begin
    rstMeta <= rst_n;
    rstTckN <= rstMeta;
  end

  always_ff @(posedge tck) begin
    holdMeta <= ctrlHold;
    holdSync <= holdMeta;
  end

  always_ff @(posedge tck) begin
    pinMeta <= '{a: aIn, b: bIn};
    pinSync <= pinMeta;
    ctlMeta <= {oeN, dir};
    ctlSync <= ctlMeta;
  end

  // Software hold forces the controller toward reset
  assign tmsEff = tms | holdSync;

  tap_fsm u_tap (
    .tck(tck),
    .rstTckN(rstTckN),
    .tms(tmsEff),
    .state(tapState),
    .ctl(tap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  always_comb begin
    selBsr = (instr == bscan_pkg::OP_EXTEST) || (instr == bscan_pkg::OP_SAMPLE);
    selBcr = (instr == bscan_pkg::OP_SCANCTL);
    selId = (instr == bscan_pkg::OP_IDCODE);
    hiz = (instr == bscan_pkg::OP_ALL_OUTPUTS_FLOATING);
    testMode = (instr == bscan_pkg::OP_EXTEST) || (instr == bscan_pkg::OP_CLAMP) || hiz ||
               (instr == bscan_pkg::OP_RUNT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction shift stage: capture and shift on the rising edge
  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      irShift <= bscan_pkg::IR_CAPTURE;
    end else if (tap.captureIr) begin
      irShift <= bscan_pkg::IR_CAPTURE;
    end else if (tap.shiftIr) begin
      irShift <= {tdi, irShift[bscan_pkg::IR_W-1:1]};
    end
  end

  // Current instruction, updated on the falling edge
  always_ff @(negedge tck) begin
    if (!rstTckN || tap.testLogicReset) begin
      instr <= bscan_pkg::IR_RESET;
    end else if (tap.updateIr) begin
      instr <= irShift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data shift stages: capture and shift on the rising edge
  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      bsrShift <= '0;
    end else if (tap.captureDr && selBsr) begin
      bsrShift <= {bsrUpd[bscan_pkg::BSR_OE_HI:OL], ctlSync, pinSync.a, pinSync.b};
    end else if (tap.shiftDr && selBsr) begin
      bsrShift <= {tdi, bsrShift[bscan_pkg::BSR_W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      bcrShift <= bscan_pkg::BCR_RESET;
    end else if (tap.captureDr && selBcr) begin
      bcrShift <= bcrUpd;
    end else if (tap.shiftDr && selBcr) begin
      bcrShift <= {tdi, bcrShift[bscan_pkg::BCR_W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      idShift <= ID_VALUE;
    end else if (tap.captureDr && selId) begin
      idShift <= ID_VALUE;
    end else if (tap.shiftDr && selId) begin
      idShift <= {tdi, idShift[bscan_pkg::ID_W-1:1]};
    end
  end

  // Bypass stage, selected by every instruction without its own register
  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      bypassReg <= 1'b0;
    end else if (tap.captureDr) begin
      bypassReg <= 1'b0;
    end else if (tap.shiftDr) begin
      bypassReg <= tdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern step used by signature compression and pattern generation
  function automatic logic [35:0] lfsrStep(input logic [35:0] v);
    lfsrStep = {v[bscan_pkg::PIN_MSB-1:0], v[bscan_pkg::PIN_MSB] ^ v[bscan_pkg::LFSR_TAP]};
  endfunction

  // Boundary update latches and run-time test operations on the falling edge
  always_ff @(negedge tck) begin
    if (!rstTckN || tap.testLogicReset) begin
      bsrUpd[bscan_pkg::BSR_OE_HI:OL] <= bscan_pkg::BSR_OE_RESET;
    end else if (tap.updateDr && selBsr) begin
      bsrUpd[bscan_pkg::BSR_OE_HI:OL] <= bsrShift[bscan_pkg::BSR_OE_HI:OL];
    end
  end

  always_ff @(negedge tck) begin
    if (tap.updateDr && selBsr) begin
      bsrUpd[OL-1:0] <= bsrShift[OL-1:0];
    end else if (tap.runIdle && instr == bscan_pkg::OP_RUNT) begin
      case (bcrUpd)
        bscan_pkg::BCR_PSA:
          bsrUpd[bscan_pkg::PIN_MSB:0] <= lfsrStep(bsrUpd[bscan_pkg::PIN_MSB:0]) ^ pinSync;
        bscan_pkg::BCR_PSEUDO_RANDOM_PATTERN_GEN:
          bsrUpd[bscan_pkg::PIN_MSB:0] <= lfsrStep(bsrUpd[bscan_pkg::PIN_MSB:0]);
        bscan_pkg::BCR_COUNT:
          bsrUpd[bscan_pkg::PIN_MSB:0] <= bsrUpd[bscan_pkg::PIN_MSB:0] + bscan_pkg::PIN_ONE;
        bscan_pkg::BCR_TOGGLE:
          bsrUpd[bscan_pkg::PIN_MSB:0] <= ~bsrUpd[bscan_pkg::PIN_MSB:0];
        default:
          bsrUpd[bscan_pkg::PIN_MSB:0] <= bsrUpd[bscan_pkg::PIN_MSB:0];
      endcase
    end
  end

  // Boundary-control latch
  always_ff @(negedge tck) begin
    if (!rstTckN || tap.testLogicReset) begin
      bcrUpd <= bscan_pkg::BCR_RESET;
    end else if (tap.updateDr && selBcr) begin
      bcrUpd <= bcrShift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on the falling edge and floated outside shifts
  always_comb begin
    if (selBsr) begin
      drOut = bsrShift[0];
    end else if (selBcr) begin
      drOut = bcrShift[0];
    end else if (selId) begin
      drOut = idShift[0];
    end else begin
      drOut = bypassReg;
    end
  end

  always_ff @(negedge tck) begin
    if (!rstTckN) begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
    end else begin
      tdoOe <= tap.shiftIr || tap.shiftDr;
      tdo <= tap.shiftIr ? irShift[0] : drOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers per section
  genvar s;
  generate
    for (s = 0; s < bscan_pkg::SECTIONS; s++) begin : g_sect
      logic normA, normB, testA, testB;
      assign normA = !oeN[s] && !dir[s];
      assign normB = !oeN[s] && dir[s];
      assign testA = !hiz && bsrUpd[OL + bscan_pkg::OE_A_OFS + s];
      assign testB = !hiz && bsrUpd[OL + s];
      assign aOe[s*SW +: SW] = {SW{testMode ? testA : normA}};
      assign bOe[s*SW +: SW] = {SW{testMode ? testB : normB}};
      assign aOut[s*SW +: SW] = testMode ? bsrUpd[AL + s*SW +: SW] : bIn[s*SW +: SW];
      assign bOut[s*SW +: SW] = testMode ? bsrUpd[BL + s*SW +: SW] : aIn[s*SW +: SW];

      a_b_to_a_path: assert property (@(posedge core_clk) disable iff (!rst_n)
        !testMode && !oeN[s] && !dir[s] |-> aOe[s*SW +: SW] == '1 && bOe[s*SW +: SW] == '0 &&
        aOut[s*SW +: SW] == bIn[s*SW +: SW]) else $error("B to A path wrong");
      a_a_to_b_path: assert property (@(posedge core_clk) disable iff (!rst_n)
        !testMode && !oeN[s] && dir[s] |-> bOe[s*SW +: SW] == '1 && aOe[s*SW +: SW] == '0 &&
        bOut[s*SW +: SW] == aIn[s*SW +: SW]) else $error("A to B path wrong");
      a_section_isolate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !testMode && oeN[s] |-> aOe[s*SW +: SW] == '0 && bOe[s*SW +: SW] == '0) else $error("Section not isolated");
      a_test_drive_cells: assert property (@(posedge core_clk) disable iff (!rst_n)
        testMode |-> aOut[s*SW +: SW] == bsrUpd[AL + s*SW +: SW]) else $error("Test mode not from cells");
    end
  endgenerate

  a_all_outputs_floating_floats_all: assert property (@(posedge core_clk) disable iff (!rst_n)
    hiz |-> aOe == '0 && bOe == '0) else $error("Float instruction drives pins");

  ////////////////////////////////////////////////////////////////////////////////
  // Test-clock checks on the scan machinery
  a_ir_reset_value: assert property (@(posedge tck) disable iff (!rstTckN)
    tap.testLogicReset |-> instr == bscan_pkg::IR_RESET && bcrUpd == bscan_pkg::BCR_RESET)
    else $error("Reset values not loaded");
  a_bsr_oe_cleared: assert property (@(posedge tck) disable iff (!rstTckN)
    tap.testLogicReset |-> bsrUpd[bscan_pkg::BSR_OE_HI:OL] == bscan_pkg::BSR_OE_RESET)
    else $error("Boundary enables not cleared");
  a_capture_ir_pattern: assert property (@(posedge tck) disable iff (!rstTckN)
    tap.captureIr |=> irShift == bscan_pkg::IR_CAPTURE) else $error("Capture-IR pattern wrong");
  a_tdo_enable_shift: assert property (@(negedge tck) disable iff (!rstTckN)
    1'b1 |=> tdoOe == $past(tap.shiftIr || tap.shiftDr)) else $error("TDO enable wrong");
  a_bypass_one_stage: assert property (@(posedge tck) disable iff (!rstTckN)
    tap.shiftDr && !selBsr && !selBcr && !selId |=> bypassReg == $past(tdi)) else $error("Bypass shift wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Status crossing into the system clock domain
  always_ff @(posedge core_clk) begin
    testMeta <= testMode;
    testSync <= testMeta;
    tlrMeta <= tap.testLogicReset;
    tlrSync <= tlrMeta;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data registered in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrlHold <= 1'b0;
    end else if (psel && penable && pwrite && paddr == bscan_pkg::ADDR_CTRL) begin
      ctrlHold <= pwdata[bscan_pkg::CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= bscan_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= bscan_pkg::ZERO_WORD;
      pslverr <= !(paddr == bscan_pkg::ADDR_CTRL || paddr == bscan_pkg::ADDR_STATUS);
      if (!pwrite && paddr == bscan_pkg::ADDR_CTRL) begin
        prdata[bscan_pkg::CTRL_HOLD_BIT] <= ctrlHold;
      end
      if (!pwrite && paddr == bscan_pkg::ADDR_STATUS) begin
        prdata[bscan_pkg::STAT_TEST_BIT] <= testSync;
        prdata[bscan_pkg::STAT_RESET_BIT] <= tlrSync;
      end
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule

// *** rtl/bscan_pkg.sv ***
// Shared constants, opcodes, states and carriers of the scan-test transceiver
package bscan_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int SECT_W = 9;
  localparam int SECTIONS = 2;
  localparam int BUS_W = 18;
  localparam int IR_W = 8;
  localparam int BSR_W = 44;
  localparam int BCR_W = 3;
  localparam int ID_W = 32;
  localparam int PIN_CELLS = 36;

  ////////////////////////////////////////////////////////////////////////////////
  // Boundary register layout: enables, observed controls, A cells, B cells
  localparam int BSR_OE_HI = 43;
  localparam int BSR_OE_LO = 40;
  localparam int BSR_CTL_LO = 36;
  localparam int BSR_A_LO = 18;
  localparam int BSR_B_LO = 0;
  localparam int OE_A_OFS = 2;  // Bits 43:42 enable A sections, 41:40 B sections
  localparam int PIN_MSB = 35;
  localparam int LFSR_TAP = 24;
  localparam logic [35:0] PIN_ONE = 36'h0_0000_0001;
  localparam logic [3:0] BSR_OE_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction opcodes, all of even parity
  localparam logic [7:0] OP_EXTEST = 8'h00;
  localparam logic [7:0] OP_IDCODE = 8'h81;
  localparam logic [7:0] OP_SAMPLE = 8'h82;
  localparam logic [7:0] OP_ALL_OUTPUTS_FLOATING = 8'h84;
  localparam logic [7:0] OP_CLAMP = 8'h88;
  localparam logic [7:0] OP_RUNT = 8'h90;
  localparam logic [7:0] OP_SCANCTL = 8'hC0;
  localparam logic [7:0] OP_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = 8'h81;

  ////////////////////////////////////////////////////////////////////////////////
  // Boundary-control operations run in Run-Test/Idle
  localparam logic [2:0] BCR_TOGGLE = 3'h0;
  localparam logic [2:0] BCR_PSEUDO_RANDOM_PATTERN_GEN = 3'h1;
  localparam logic [2:0] BCR_PSA = 3'h2;
  localparam logic [2:0] BCR_COUNT = 3'h4;
  localparam logic [2:0] BCR_RESET = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // APB register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_TEST_BIT = 0;
  localparam int STAT_RESET_BIT = 1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tapState_e;

  typedef struct packed {
    logic testLogicReset;
    logic runIdle;
    logic captureDr;
    logic shiftDr;
    logic updateDr;
    logic captureIr;
    logic shiftIr;
    logic updateIr;
  } tapCtl_s;

  typedef struct packed {
    logic [BUS_W-1:0] a;
    logic [BUS_W-1:0] b;
  } pinBus_s;

endpackage

// *** rtl/tap_fsm.sv ***
// Sixteen-state test access port controller on the test clock
`timescale 1ns/100ps
module tap_fsm (
  input wire logic tck,                    // Test clock
  input wire logic rstTckN,                // Synchronised reset, active low
  input wire logic tms,                    // Mode select sampled on rising edge
  output bscan_pkg::tapState_e state,      // Current controller state
  output bscan_pkg::tapCtl_s ctl           // Decoded state strobes
);

  bscan_pkg::tapState_e next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state from the sampled mode select
  always_comb begin
    case (state)
      bscan_pkg::ST_RESET: next_state = tms ? bscan_pkg::ST_RESET : bscan_pkg::ST_IDLE;
      bscan_pkg::ST_IDLE: next_state = tms ? bscan_pkg::ST_SEL_DR : bscan_pkg::ST_IDLE;
      bscan_pkg::ST_SEL_DR: next_state = tms ? bscan_pkg::ST_SEL_IR : bscan_pkg::ST_CAP_DR;
      bscan_pkg::ST_CAP_DR: next_state = tms ? bscan_pkg::ST_EXIT1_DR : bscan_pkg::ST_SHIFT_DR;
      bscan_pkg::ST_SHIFT_DR: next_state = tms ? bscan_pkg::ST_EXIT1_DR : bscan_pkg::ST_SHIFT_DR;
      bscan_pkg::ST_EXIT1_DR: next_state = tms ? bscan_pkg::ST_UPD_DR : bscan_pkg::ST_PAUSE_DR;
      bscan_pkg::ST_PAUSE_DR: next_state = tms ? bscan_pkg::ST_EXIT2_DR : bscan_pkg::ST_PAUSE_DR;
      bscan_pkg::ST_EXIT2_DR: next_state = tms ? bscan_pkg::ST_UPD_DR : bscan_pkg::ST_SHIFT_DR;
      bscan_pkg::ST_UPD_DR: next_state = tms ? bscan_pkg::ST_SEL_DR : bscan_pkg::ST_IDLE;
      bscan_pkg::ST_SEL_IR: next_state = tms ? bscan_pkg::ST_RESET : bscan_pkg::ST_CAP_IR;
      bscan_pkg::ST_CAP_IR: next_state = tms ? bscan_pkg::ST_EXIT1_IR : bscan_pkg::ST_SHIFT_IR;
      bscan_pkg::ST_SHIFT_IR: next_state = tms ? bscan_pkg::ST_EXIT1_IR : bscan_pkg::ST_SHIFT_IR;
      bscan_pkg::ST_EXIT1_IR: next_state = tms ? bscan_pkg::ST_UPD_IR : bscan_pkg::ST_PAUSE_IR;
      bscan_pkg::ST_PAUSE_IR: next_state = tms ? bscan_pkg::ST_EXIT2_IR : bscan_pkg::ST_PAUSE_IR;
      bscan_pkg::ST_EXIT2_IR: next_state = tms ? bscan_pkg::ST_UPD_IR : bscan_pkg::ST_SHIFT_IR;
      bscan_pkg::ST_UPD_IR: next_state = tms ? bscan_pkg::ST_SEL_DR : bscan_pkg::ST_IDLE;
      default: next_state = bscan_pkg::ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, advanced on the rising test clock edge only
  always_ff @(posedge tck) begin
    if (!rstTckN) begin
      state <= bscan_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // State strobes
  assign ctl.testLogicReset = (state == bscan_pkg::ST_RESET);
  assign ctl.runIdle = (state == bscan_pkg::ST_IDLE);
  assign ctl.captureDr = (state == bscan_pkg::ST_CAP_DR);
  assign ctl.shiftDr = (state == bscan_pkg::ST_SHIFT_DR);
  assign ctl.updateDr = (state == bscan_pkg::ST_UPD_DR);
  assign ctl.captureIr = (state == bscan_pkg::ST_CAP_IR);
  assign ctl.shiftIr = (state == bscan_pkg::ST_SHIFT_IR);
  assign ctl.updateIr = (state == bscan_pkg::ST_UPD_IR);

  a_tms_five_reset: assert property (@(posedge tck) disable iff (!rstTckN)
    tms [*5] |=> state == bscan_pkg::ST_RESET) else $error("TAP not reset after five high TMS");

  a_reset_leave_idle: assert property (@(posedge tck) disable iff (!rstTckN)
    state == bscan_pkg::ST_RESET && !tms |=> state == bscan_pkg::ST_IDLE) else $error("TAP did not enter idle");

endmodule

// *** tb/scan_partner.sv ***
// Far side model: board scan controller and the two system buses
`timescale 1ns/100ps
module scan_partner (
  input wire logic [17:0] aOut, // A drive value
  input wire logic [17:0] aOe, // A drive enable
  input wire logic [17:0] bOut, // B drive value
  input wire logic [17:0] bOe, // B drive enable
  input wire logic tdo, // Serial data from device
  output logic [17:0] aIn, // A bus level
  output logic [17:0] bIn, // B bus level
  output logic tck, // Test clock, still between frames
  output logic tms, // Mode select, idles high
  output logic tdi // Serial data to device
);
  logic [17:0] farA = 18'h2_A5C3;
  logic [17:0] farB = 18'h1_3C96;
  logic [17:0] farOn = 18'h0_0000; // Far A drives these bits, far B the rest

  initial begin
    tck = 0;
    tms = 1;
    tdi = 1;
  end

  // Resolve each bus; a bit nobody drives shows the inverse of the far value
  assign aIn = (aOe & aOut) | (~aOe & farOn & farA) | (~aOe & ~farOn & ~farA);
  assign bIn = (bOe & bOut) | (~bOe & ~farOn & farB) | (~bOe & farOn & ~farB);

  // One test clock per bit: inputs set while low, tdo taken before the rise
  task automatic shift(input int n, input logic [63:0] mv, dv, output logic [63:0] ov);
    ov = '0;
    #1.3;
    for (int i = 0; i < n; i++) begin
      tms = mv[i];
      tdi = dv[i];
      #80 ov[i] = tdo;
      tck = 1;
      #80 tck = 0;
    end
    tms = 1;
    tdi = 1;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the scan-test transceiver
`timescale 1ns/100ps
module testbench;
  logic coreClk = 0, rstN = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, tck, tms, tdi, tdo, tdoOe;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] oeN = 2'h3, dir = 2'h0;
  logic [17:0] aIn, aOut, aOe, bIn, bOut, bOe;
  logic [63:0] cap;
  logic err;
  int errors = 0, totalChecks = 0, cycles = 0;
  localparam logic [31:0] ID = 32'h3C5A_0F01; // Identification word, value arbitrary

  scan_transceiver #(.ID_VALUE(ID)) i_scan_transceiver (.core_clk(coreClk), .rst_n(rstN), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .oeN(oeN), .dir(dir),
    .aIn(aIn), .aOut(aOut), .aOe(aOe), .bIn(bIn), .bOut(bOut), .bOe(bOe));
  scan_partner i_scan_partner (.aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .tdo(tdo), .aIn(aIn),
    .bIn(bIn), .tck(tck), .tms(tms), .tdi(tdi));

  initial forever #2 coreClk = ~coreClk;

  // Cut a hang short
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      stop_test();
    end
  end

  task stop_test();
    $display("Checks %0d, errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input logic [63:0] seen, exp, input string msg);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and scan helpers
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge coreClk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge coreClk);
    penable <= 1;
    @(posedge coreClk);
    while (pready !== 1'b1) @(posedge coreClk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task ir(input logic [7:0] op);
    i_scan_partner.shift(14, 64'h1803, {52'h0, op, 4'h0}, cap);
    cap = (cap >> 4) & 64'hFF;
  endtask

  task dr(input int n, input logic [63:0] d);
    i_scan_partner.shift(n + 5, 64'h1 | (64'h3 << (n + 2)), d << 3, cap);
    cap = (cap >> 3) & ((64'h1 << n) - 1);
  endtask

  // Set section controls and far drivers, then judge the normal path
  task pins(input logic [1:0] o, d);
    logic [17:0] en, ea, eb;
    oeN <= o;
    dir <= d;
    i_scan_partner.farOn <= {{9{d[1]}}, {9{d[0]}}};
    repeat (2) @(posedge coreClk);
    en = ~{{9{o[1]}}, {9{o[0]}}};
    ea = en & ~{{9{d[1]}}, {9{d[0]}}};
    eb = en & {{9{d[1]}}, {9{d[0]}}};
    check(aOe, ea, "A enable");
    check(bOe, eb, "B enable");
    check(aOut & ea, i_scan_partner.farB & ea, "A data");
    check(bOut & eb, i_scan_partner.farA & eb, "B data");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task reset_values();
    apb(0, 12'h004, '0);
    check(rd[1:0], 2'h2, "status after reset");
    apb(1, 12'h000, 32'h0000_0001);
    apb(0, 12'h000, '0);
    check(rd, 32'h0000_0001, "ctrl readback");
    apb(1, 12'h000, '0);
    apb(0, 12'h00C, '0);
    check({err, rd}, {1'b1, 32'h0000_0000}, "unmapped");
    check(tdoOe, 1'b0, "tdo floats");
  endtask

  task normal_path();
    for (int i = 0; i < 16; i++) pins(i[1:0], i[3:2]);
  endtask

  task scan_regs();
    i_scan_partner.shift(1, '0, '0, cap);
    dr(32, '0);
    check(cap, ID, "identification");
    ir(bscan_pkg::OP_BYPASS);
    check(cap, 64'h81, "ir capture");
    dr(8, 64'hA5);
    check(cap, 64'h4A, "bypass delay");
  endtask

  task sample_mode();
    ir(bscan_pkg::OP_SAMPLE);
    pins(2'h0, 2'h2);
    dr(44, '0);
    check(cap[43:18], {8'h02, i_scan_partner.farA[17:9], i_scan_partner.farB[8:0]}, "capture");
    pins(2'h0, 2'h2);
  endtask

  task float_mode();
    ir(bscan_pkg::OP_ALL_OUTPUTS_FLOATING);
    repeat (4) @(posedge coreClk);
    check({aOe, bOe}, '0, "all float");
    apb(0, 12'h004, '0);
    check(rd[1:0], 2'h1, "test mode");
    i_scan_partner.shift(5, 64'h1F, '0, cap);
    repeat (8) @(posedge coreClk);
    apb(0, 12'h004, '0);
    check(rd[1:0], 2'h2, "back to reset");
    pins(2'h0, 2'h1);
  endtask

  // Boundary cells drive the pins, then the control register steers run-time ops in idle
  task test_ops();
    i_scan_partner.shift(1, '0, '0, cap);
    ir(bscan_pkg::OP_EXTEST);
    dr(44, {20'h0, 4'hF, 4'h0, 18'h1_2345, 18'h2_6789});
    repeat (4) @(posedge coreClk);
    check({aOe, bOe}, {36{1'b1}}, "cells enable");
    check({aOut, bOut}, {18'h1_2345, 18'h2_6789}, "cells drive");
    ir(bscan_pkg::OP_SCANCTL);
    dr(3, 64'h4);
    check(cap, 64'h2, "control reset");
    ir(bscan_pkg::OP_RUNT);
    i_scan_partner.shift(4, '0, '0, cap);
    repeat (4) @(posedge coreClk);
    check({aOut, bOut}, {18'h1_2345, 18'h2_678E}, "binary count");
    ir(bscan_pkg::OP_SCANCTL);
    dr(3, 64'h1);
    check(cap, 64'h4, "control readback");
    ir(bscan_pkg::OP_RUNT);
    repeat (4) @(posedge coreClk);
    check({aOut, bOut}, {18'h2_468B, 18'h0_CF1D}, "pattern step");
  endtask

  initial begin
    fork
      repeat (16) @(posedge coreClk);
      i_scan_partner.shift(5, 64'h1F, '0, cap);
    join
    @(posedge coreClk);
    rstN <= 1;
    i_scan_partner.shift(3, 64'h7, '0, cap);
    reset_values();
    normal_path();
    scan_regs();
    sample_mode();
    float_mode();
    test_ops();
    stop_test();
  end
endmodule
